//--- hw/adc_seq_defines.svh
// Offsets, field positions, reset values and counts of the sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COMMON 8'h08
`define OFS_CHAN_BASE 8'h20
`define OFS_CHAN_LAST 8'h3C
`define CTRL_OPT_RST 2'h3
`define COMMON_RST 8'h00
`define ST_BUSY_POS 0
`define ST_STATE_POS 1
`define ST_RESULT_POS 8
`define ST_COUNT_POS 16
`define FETCH_PLUS 2'h1
`define FETCH_MINUS 2'h2
`define FETCH_END 2'h3
`define RD_LOAD 2'h1
`define RD_DONE 2'h2
`define PIN_RST 4'h8
`endif

//--- hw/adc_seq_pkg.sv
// Types shared by the serial conversion sequencer
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV = 3'b011,
    ST_LSB = 3'b100,
    ST_LOW = 3'b101
  } seq_state_t;
  typedef enum logic [1:0] {
    OPT_ONE = 2'b00,
    OPT_TWO = 2'b01,
    OPT_FOUR = 2'b10,
    OPT_EIGHT = 2'b11
  } chan_opt_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;
  typedef struct packed {
    logic sel_n;
    logic ser_clk;
    logic serial_in;
    logic lsb_order_enable;
  } link_in_t;
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe_n;
    logic approx_busy_flag;
  } link_out_t;
endpackage

//--- hw/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      sync <= RST_VAL;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule

//--- hw/chan_mem.sv
// Channel sample memory with registered read ports
`timescale 1ns/10ps
module chan_mem #(
  parameter int DW = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [DW-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_b
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // One write port, two registered read ports
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

//--- hw/adc_seq_top.sv
// Serial conversion sequencer with an Avalon-MM register slave
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_seq_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire adc_seq_pkg::av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire adc_seq_pkg::link_in_t link_in,
  output adc_seq_pkg::link_out_t link_out
);
  import adc_seq_pkg::*;

  link_in_t pins;
  logic clk_prev;
  seq_state_t state;
  chan_opt_t opt;
  logic [7:0] common_code;
  logic [7:0] plus_code;
  logic [7:0] diff;
  logic [7:0] approx_acc;
  logic [7:0] result;
  logic [7:0] out_sr;
  logic [7:0] conv_cnt;
  logic [7:0] mem_a;
  logic [7:0] mem_b;
  logic [3:0] addr_sr;
  logic [2:0] addr_cnt;
  logic [2:0] bit_idx;
  logic [2:0] lsb_cnt;
  logic [1:0] fetch_cnt;
  logic [1:0] rd_phase;
  logic busy;
  logic sdo;
  logic sdo_oe_n;
  logic [31:0] rd_mux;

  // Number of assignment bits for each channel option
  function automatic logic [2:0] addr_len(input chan_opt_t o);
    case (o)
      OPT_TWO: addr_len = 3'h2;
      OPT_FOUR: addr_len = 3'h3;
      OPT_EIGHT: addr_len = 3'h4;
      default: addr_len = 3'h0;
    endcase
  endfunction

  // Assignment word to {single-ended, positive channel}
  function automatic logic [3:0] chan_decode(input chan_opt_t o, input logic [3:0] a);
    case (o)
      OPT_TWO: chan_decode = {a[1], 2'h0, a[0]};
      OPT_FOUR: chan_decode = {a[2], 1'h0, a[0], a[1]};
      OPT_EIGHT: chan_decode = {a[3], a[1:0], a[2]};
      default: chan_decode = 4'h0;
    endcase
  endfunction

  // Pins cross into the system clock through two flops
  pin_sync #(
    .WIDTH(4),
    .RST_VAL(`PIN_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(link_in),
    .sync(pins)
  );

  // Serial clock edge detection on the synchronised level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= pins.ser_clk;
    end
  end

  // Link events
  wire sel_idle = pins.sel_n;
  wire rise = pins.ser_clk & ~clk_prev;
  wire fall = ~pins.ser_clk & clk_prev;
  wire [2:0] need = addr_len(opt);
  wire addr_last = (addr_cnt + 3'h1) == need;
  wire start_seen = (state == ST_IDLE) & rise & pins.serial_in;
  wire start_only = start_seen & (need == 3'h0);
  wire addr_done = start_only | ((state == ST_ADDR) & rise & addr_last);
  wire settle_fall = (state == ST_SETTLE) & fall;
  wire conv_fall = (state == ST_CONV) & fall;
  wire conv_end = conv_fall & (bit_idx == 3'h7);
  wire lsb_hold = (opt == OPT_EIGHT) & pins.lsb_order_enable;
  wire lsb_fall = (state == ST_LSB) & fall;
  wire lsb_end = lsb_fall & ((opt == OPT_ONE) | (lsb_cnt == 3'h7));
  wire lsb_step = lsb_fall & ~lsb_end & ~lsb_hold;
  wire out_next_bit = out_sr[1];

  // Channel selection from the captured word
  wire [3:0] dec = chan_decode(opt, addr_sr);
  wire single = dec[3];
  wire [2:0] plus_ch = dec[2:0];
  wire [2:0] minus_ch = plus_ch ^ 3'h1;
  wire [2:0] chan_b = (fetch_cnt >= `FETCH_MINUS) ? minus_ch : plus_ch;
  wire [7:0] fixed_minus = (opt == OPT_EIGHT) ? common_code : 8'h00;
  wire [7:0] minus_now = single ? fixed_minus : mem_b;
  wire [7:0] trial = approx_acc | (8'h80 >> bit_idx);
  wire decide = diff >= trial;
  wire [7:0] final_code = decide ? trial : approx_acc;

  // Bus decode
  wire is_ctrl = av_req.address == `OFS_CTRL;
  wire is_status = av_req.address == `OFS_STATUS;
  wire is_common = av_req.address == `OFS_COMMON;
  wire in_chan = (av_req.address >= `OFS_CHAN_BASE) & (av_req.address <= `OFS_CHAN_LAST);
  wire is_chan = in_chan & (av_req.address[1:0] == 2'h0);
  wire wr_lane0 = av_req.write & av_req.byteenable[0];
  wire [2:0] chan_idx = av_req.address[4:2];
  wire [31:0] status_word = (32'(busy) << `ST_BUSY_POS) | (32'(state) << `ST_STATE_POS)
    | (32'(result) << `ST_RESULT_POS) | (32'(conv_cnt) << `ST_COUNT_POS);

  chan_mem #(
    .DW(8),
    .AW(3)
  ) u_mem (
    .sys_clk(sys_clk),
    .we(wr_lane0 & is_chan),
    .waddr(chan_idx),
    .wdata(av_req.writedata[7:0]),
    .raddr_a(chan_idx),
    .rdata_a(mem_a),
    .raddr_b(chan_b),
    .rdata_b(mem_b)
  );

  // Sequence state and counters, held clear while select is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      addr_sr <= 4'h0;
      addr_cnt <= 3'h0;
      fetch_cnt <= 2'h0;
      bit_idx <= 3'h0;
      lsb_cnt <= 3'h0;
    end else if (sel_idle) begin
      state <= ST_IDLE;
      addr_sr <= 4'h0;
      addr_cnt <= 3'h0;
      fetch_cnt <= 2'h0;
      bit_idx <= 3'h0;
      lsb_cnt <= 3'h0;
    end else begin
      if (addr_done) begin
        state <= ST_SETTLE;
      end else if (start_seen) begin
        state <= ST_ADDR;
      end else if (settle_fall) begin
        state <= ST_CONV;
      end else if (conv_end) begin
        state <= ST_LSB;
      end else if (lsb_end) begin
        state <= ST_LOW;
      end
      if ((state == ST_ADDR) & rise) begin
        addr_sr <= {addr_sr[2:0], pins.serial_in};
        addr_cnt <= addr_cnt + 3'h1;
      end
      if ((state == ST_SETTLE) & (fetch_cnt != `FETCH_END)) begin
        fetch_cnt <= fetch_cnt + 2'h1;
      end
      if (conv_fall) begin
        bit_idx <= bit_idx + 3'h1;
      end
      if (lsb_step) begin
        lsb_cnt <= lsb_cnt + 3'h1;
      end
    end
  end

  // Sampling and approximation datapath
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      plus_code <= 8'h00;
      diff <= 8'h00;
      approx_acc <= 8'h00;
      out_sr <= 8'h00;
    end else if (sel_idle) begin
      plus_code <= 8'h00;
      diff <= 8'h00;
      approx_acc <= 8'h00;
      out_sr <= 8'h00;
    end else begin
      if ((state == ST_SETTLE) & (fetch_cnt == `FETCH_PLUS)) begin
        plus_code <= mem_b;
      end
      if (settle_fall) begin
        diff <= (plus_code > minus_now) ? plus_code - minus_now : 8'h00;
      end
      if (conv_fall) begin
        approx_acc <= final_code;
      end
      if (conv_end) begin
        out_sr <= final_code;
      end else if (lsb_step) begin
        out_sr <= {1'b0, out_sr[7:1]};
      end
    end
  end

  // Software-visible result and conversion count survive select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result <= 8'h00;
      conv_cnt <= 8'h00;
    end else if (conv_end & ~sel_idle) begin
      result <= final_code;
      conv_cnt <= conv_cnt + 8'h01;
    end
  end

  // Busy flag and serial output drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (sel_idle) begin
      busy <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      if (addr_done) begin
        busy <= 1'b1;
      end else if (rise & ((state == ST_LSB) | (state == ST_LOW))) begin
        busy <= 1'b0;
      end
      if (settle_fall) begin
        sdo_oe_n <= 1'b0;
        sdo <= 1'b0;
      end else if (conv_fall) begin
        sdo <= decide;
      end else if (lsb_step) begin
        sdo <= out_next_bit;
      end else if (lsb_end) begin
        sdo <= 1'b0;
      end
    end
  end

  assign link_out = '{serial_out: sdo, serial_out_oe_n: sdo_oe_n, approx_busy_flag: busy};

  // Read data selection
  always_comb begin
    if (is_ctrl) begin
      rd_mux = {30'h0, opt};
    end else if (is_status) begin
      rd_mux = status_word;
    end else if (is_common) begin
      rd_mux = {24'h0, common_code};
    end else if (is_chan) begin
      rd_mux = {24'h0, mem_a};
    end else begin
      rd_mux = 32'h0;
    end
  end

  // Reads wait two cycles for the registered memory port
  assign av_waitrequest = av_req.read & (rd_phase != `RD_DONE);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_phase <= 2'h0;
      av_readdata <= 32'h0;
    end else begin
      if (av_req.read & (rd_phase != `RD_DONE)) begin
        rd_phase <= rd_phase + 2'h1;
      end else begin
        rd_phase <= 2'h0;
      end
      if (av_req.read & (rd_phase == `RD_LOAD)) begin
        av_readdata <= rd_mux;
      end
    end
  end

  // Control register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt <= chan_opt_t'(`CTRL_OPT_RST);
      common_code <= `COMMON_RST;
    end else if (wr_lane0) begin
      if (is_ctrl) begin
        opt <= chan_opt_t'(av_req.writedata[1:0]);
      end else if (is_common) begin
        common_code <= av_req.writedata[7:0];
      end
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence lsb_shift_s;
    lsb_step && !sel_idle;
  endsequence
  sequence conv_last_s;
    conv_end && !sel_idle;
  endsequence

  addr_gate_a: assert property (busy && !sel_idle |=> $stable(addr_sr))
    else $error("address register changed while busy");
  settle_start_a: assert property (addr_done && !sel_idle |=> busy && state == ST_SETTLE)
    else $error("settling did not start after the address");
  lead_zero_a: assert property (settle_fall && !sel_idle |=> !sdo_oe_n && !sdo)
    else $error("no leading zero at settling");
  msb_first_a: assert property (conv_fall && bit_idx == 3'h0 && !sel_idle
    |=> sdo == (diff >= 8'h80))
    else $error("first output bit is not the MSB decision");
  busy_hold_a: assert property (conv_last_s |=> busy && state == ST_LSB)
    else $error("busy fell with the last bit");
  busy_fall_a: assert property ((state == ST_LSB) && rise && !sel_idle |=> !busy)
    else $error("busy did not fall half a clock after conversion");
  lsb_order_a: assert property (lsb_shift_s |=> sdo == $past(out_next_bit))
    else $error("LSB-first stream out of order");
  tail_low_a: assert property (lsb_end && !sel_idle |=> state == ST_LOW && !sdo)
    else $error("serial output not low after the stream");
  order_hold_a: assert property (lsb_fall && lsb_hold && !lsb_end && !sel_idle
    |=> $stable(sdo))
    else $error("LSB not held while order input is high");
  clear_sel_a: assert property (sel_idle |=> state == ST_IDLE && diff == 8'h00 && !busy)
    else $error("state not cleared while select high");
  float_idle_a: assert property (sel_idle |=> sdo_oe_n)
    else $error("serial output driven while select high");
  zero_neg_a: assert property (settle_fall && !sel_idle && minus_now >= plus_code
    |=> diff == 8'h00)
    else $error("negative difference not clamped to zero");
  start_skip_a: assert property (state == ST_IDLE && rise && !pins.serial_in && !sel_idle
    |=> state == ST_IDLE)
    else $error("leading zero taken as start");
endmodule

//--- test/serial_host.sv
// Host model that drives the serial link and records what the converter returns
`timescale 1ns/10ps
module serial_host (
  input wire logic sys_clk,
  input wire adc_seq_pkg::link_out_t link_out,
  output adc_seq_pkg::link_in_t link_in
);
  import adc_seq_pkg::*;
  logic noise = 1'b0;
  // Idle link: deselected, clock parked low
  initial link_in = '{1'b1, 1'b0, 1'b0, 1'b1};
  // Waits whole cycles; a data line that is not being read toggles every cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (noise) link_in.serial_in <= ~link_in.serial_in;
    end
  endtask
  // One frame: select, start bit and word, then nf clocks of readout
  task automatic convert(input logic [7:0] bits, input int nb, input int nf, input int hold,
                         output logic [31:0] seen, output logic [31:0] busy);
    seen = '0;
    busy = '0;
    @(posedge sys_clk);
    noise = 1'b0;
    link_in.sel_n <= 1'b0;
    link_in.serial_in <= 1'b0;
    link_in.lsb_order_enable <= 1'b1;
    tick(20);
    // Bits go out MSB first, set up while the clock is low
    for (int i = nb - 1; i >= 0; i--) begin
      link_in.serial_in <= bits[i];
      tick(10);
      link_in.ser_clk <= 1'b1;
      tick(10);
      link_in.ser_clk <= 1'b0;
    end
    noise = 1'b1;
    // Sample just before each rise; order input low from fall nine plus hold
    for (int k = 0; k < nf; k++) begin
      tick(9);
      // A floating line reads as pulled high, so the leading zero also proves the drive
      seen = {seen[30:0], link_out.serial_out | link_out.serial_out_oe_n};
      busy = {busy[30:0], link_out.approx_busy_flag};
      link_in.lsb_order_enable <= (k < 8 + hold);
      tick(1);
      link_in.ser_clk <= 1'b1;
      tick(10);
      link_in.ser_clk <= 1'b0;
    end
    tick(10);
    link_in.sel_n <= 1'b1;
  endtask
endmodule

//--- test/test_serial_adc_conversion_sequencer.sv
// Self-checking bench for the serial conversion sequencer
`timescale 1ns/10ps
module test_serial_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  typedef struct packed {
    logic [1:0] opt;
    logic [7:0] bits;
    logic [3:0] nb;
    logic [7:0] code;
  } row_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] be;
    logic [31:0] exp;
  } reg_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  av_req_t av_req = '0;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  link_in_t link_in;
  link_out_t link_out;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] seen;
  logic [31:0] busy;
  logic [31:0] rd;
  // Option, start bit with word, bit count, expected code
  row_t rows [9] = '{'{2'h3, 8'h1B, 4'h5, 8'h2B}, '{2'h3, 8'h16, 4'h5, 8'h00},
    '{2'h3, 8'h12, 4'h5, 8'h20}, '{2'h3, 8'h18, 4'h5, 8'hEB}, '{2'h2, 8'h0D, 4'h4, 8'hB0},
    '{2'h2, 8'h0B, 4'h4, 8'h00}, '{2'h1, 8'h07, 4'h3, 8'hD0}, '{2'h1, 8'h04, 4'h3, 8'h20},
    '{2'h0, 8'h01, 4'h1, 8'h20}};
  // Write then read back: read-only, byte enable, upper bits, unmapped, channel port
  reg_row_t regs [6] = '{'{8'h04, 32'hFFFFFFFF, 4'hF, 32'h00092000},
    '{8'h00, 32'hFFFFFFFF, 4'hE, 32'h0}, '{8'h00, 32'hFFFFFFFF, 4'hF, 32'h3},
    '{8'h10, 32'hFFFFFFFF, 4'hF, 32'h0}, '{8'h08, 32'hFFFFFFFF, 4'h1, 32'hFF},
    '{8'h24, 32'h000000A5, 4'hF, 32'hA5}};

  always #5 sys_clk = ~sys_clk;

  adc_seq_top adc_seq_top_inst (.sys_clk(sys_clk), .rst(rst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .link_in(link_in),
    .link_out(link_out));
  serial_host serial_host_inst (.sys_clk(sys_clk), .link_out(link_out), .link_in(link_in));

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // Avalon transfer held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] data);
    int n;
    @(posedge sys_clk);
    av_req <= '{addr, ~wr, wr, wd, be};
    n = 0;
    // Waitrequest and read data are both taken at the rising edge that ends the wait
    do begin
      @(posedge sys_clk);
      n++;
    end while (av_waitrequest);
    data = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    // Writes never wait; reads stand two wait cycles for the registered memory port
    check(n, wr ? 32'h1 : 32'h3);
  endtask

  // Twenty samples: leading zero, MSB first, LSB-first tail unless one channel, then zeros
  function automatic logic [31:0] stream(input logic [1:0] opt, input logic [7:0] code,
                                         input int hold);
    logic [31:0] s;
    int n;
    s = {24'h0, code};
    n = 9;
    if (opt != 2'h0) begin
      repeat (hold) s = {s[30:0], code[0]};
      for (int i = 1; i < 8; i++) s = {s[30:0], code[i]};
      n = n + hold + 7;
    end
    return s << (20 - n);
  endfunction

  // One conversion, its output stream, busy timing and release of the line
  task automatic run(input row_t r, input int hold, input logic [7:0] exp);
    serial_host_inst.convert(r.bits, int'(r.nb), 20, hold, seen, busy);
    check(seen, stream(r.opt, exp, hold));
    check(busy, 32'h000FF800);
    repeat (8) @(posedge sys_clk);
    check({30'h0, link_out.serial_out_oe_n, link_out.approx_busy_flag}, 32'h2);
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Channel codes stand in for the analog inputs; COMMON is the shared minus for single-ended eight-channel conversions
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h20 + 8'(4 * i), {24'h0, 8'hF0 - 8'(32 * i)}, 4'hF, rd);
    end
    bus(1'b1, 8'h08, 32'h5, 4'h1, rd);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {30'h0, rows[i].opt}, 4'h1, rd);
      run(rows[i], 0, rows[i].code);
      bus(1'b0, 8'h04, 32'h0, 4'hF, rd);
      check(rd, {8'h00, 8'(i + 1), rows[i].code, 8'h00});
    end
    foreach (regs[i]) begin
      bus(1'b1, regs[i].addr, regs[i].data, regs[i].be, rd);
      bus(1'b0, regs[i].addr, 32'h0, 4'hF, rd);
      check(rd, regs[i].exp);
    end
    bus(1'b1, 8'h08, 32'h5, 4'h1, rd);
    // Three zeros before the start bit on the four-channel option
    bus(1'b1, 8'h00, 32'h2, 4'h1, rd);
    run('{2'h2, 8'h0D, 4'h7, 8'h00}, 0, 8'hB0);
    // Order input held high for three falls on the eight-channel option
    bus(1'b1, 8'h00, 32'h3, 4'h1, rd);
    run(rows[0], 3, 8'h2B);
    // Select raised mid-conversion, then a clean conversion
    serial_host_inst.convert(8'h1B, 5, 4, 0, seen, busy);
    repeat (8) @(posedge sys_clk);
    check({30'h0, link_out.serial_out_oe_n, link_out.approx_busy_flag}, 32'h2);
    run(rows[0], 0, 8'h2B);
    // Second reset: register defaults and a floating output
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    check({30'h0, link_out.serial_out_oe_n, link_out.approx_busy_flag}, 32'h2);
    bus(1'b0, 8'h00, 32'h0, 4'hF, rd);
    check(rd, 32'h3);
    bus(1'b0, 8'h08, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    bus(1'b0, 8'h04, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    finish_test();
  end
endmodule
